// *** pkg/sdc_params.svh ***
// constants for the sdram command decoder: mode word layout, codes, timing
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

// mode word field positions
`define SDC_MODE_BL_LSB 0
`define SDC_MODE_BL_MSB 2
`define SDC_MODE_BT_BIT 3
`define SDC_MODE_CL_LSB 4
`define SDC_MODE_CL_MSB 6
`define SDC_MODE_OP_LSB 7
`define SDC_MODE_OP_MSB 8
`define SDC_MODE_WS_BIT 9
// power-up mode word: latency two, burst of one, normal mode
`define SDC_MODE_RESET 12'h020

// field codes
`define SDC_CL_TWO 3'h2
`define SDC_CL_THREE 3'h3
`define SDC_BL_ONE 3'h0
`define SDC_BL_TWO 3'h1
`define SDC_BL_FOUR 3'h2
`define SDC_BL_EIGHT 3'h3
`define SDC_BL_PAGE 3'h7
`define SDC_OP_NORMAL 2'h0

// address bit that selects auto precharge / all banks
`define SDC_AP_BIT 10

// timing: clock rate, precharge time in ns, mode load gap in clocks
`define SDC_CLK_MHZ 50
`define SDC_TRP_NS 20
`define SDC_TRP_CYC (((`SDC_TRP_NS * `SDC_CLK_MHZ) + 999) / 1000)
`define SDC_TMRD_CYC 2

// write data buffer depth
`define SDC_FIFO_DEPTH 16

`endif

// *** pkg/sdc_pkg.sv ***
// types shared by the sdram command decoder
`default_nettype none

package sdc_pkg;

	// command code: {inhibit, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		SDC_CMD_LMR = 4'h0,
		SDC_CMD_REF = 4'h1,
		SDC_CMD_PRE = 4'h2,
		SDC_CMD_ACT = 4'h3,
		SDC_CMD_WR  = 4'h4,
		SDC_CMD_RD  = 4'h5,
		SDC_CMD_BST = 4'h6,
		SDC_CMD_NOP = 4'h7,
		SDC_CMD_INH = 4'h8
	} sdc_cmd_e;

	// burst engine state
	typedef enum logic [2:0] {
		SDC_IDLE = 3'b001,
		SDC_RD   = 3'b010,
		SDC_WR   = 3'b100
	} sdc_burst_e;

endpackage

`default_nettype wire

// *** hw/sdc_fifo.sv ***
// write beat buffer: parameterised fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sdc_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic         clock_i,
	input  wire logic         reset_i,
	input  wire logic         en_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	// refuse depths the pointer wrap cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad
		$error("sdc_fifo: DEPTH must be a power of two >= 2");
	end

	logic [W-1:0]  store [0:DEPTH-1];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   count_reg;
	wire logic     push;
	wire logic     pop;

	// handshakes
	assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign out_data_o  = store[rd_ptr_reg];
	assign push        = en_i & in_valid_i & in_ready_o;
	assign pop         = en_i & out_valid_o & out_ready_i;

	// storage array
	always_ff @(posedge clock_i) begin
		if (push) begin
			store[wr_ptr_reg] <= in_data_i;
		end
	end

	// pointers and fill count
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule // sdc_fifo

`default_nettype wire

// *** hw/sdc_device.sv ***
// sdram device side: command decode, mode word, banks, bursts, data masks
`timescale 1ns/1ps
`default_nettype none

`include "sdc_params.svh"

module sdc_device
	import sdc_pkg::*;
#(
	parameter int DQ_W       = 16,
	parameter int LANES      = 2,
	parameter int COL_W      = 8,
	parameter int ROW_KEEP_W = 2,
	parameter int TRP_CYC    = `SDC_TRP_CYC,
	parameter int TMRD_CYC   = `SDC_TMRD_CYC,
	parameter int FIFO_DEPTH = `SDC_FIFO_DEPTH
) (
	input  wire logic            clock_i,
	input  wire logic            reset_i,
	input  wire logic            ce_i,
	input  wire logic            cke_i,
	input  wire logic            cs_n_i,
	input  wire logic            ras_n_i,
	input  wire logic            cas_n_i,
	input  wire logic            we_n_i,
	input  wire logic [1:0]      ba_i,
	input  wire logic [11:0]     addr_i,
	input  wire logic [LANES-1:0] dqm_i,
	input  wire logic [DQ_W-1:0] dq_i,
	output logic [DQ_W-1:0]      dq_o,
	output logic [DQ_W-1:0]      dq_oe_o,
	output logic [3:0]           bank_open_o,
	output logic                 self_refresh_o,
	output logic [11:0]          refresh_row_o,
	output logic                 protocol_error_o,
	output logic                 write_overflow_o,
	output logic                 wr_fifo_ready_o
);
	localparam int LW    = DQ_W / LANES;
	localparam int IDX_W = 2 + ROW_KEEP_W + COL_W;
	localparam int CW    = 8;
	localparam int FW    = IDX_W + LANES + DQ_W;

	// refuse shapes the logic cannot serve
	if (LANES < 1 || LW * LANES != DQ_W || COL_W < 3 || COL_W > 10 || ROW_KEEP_W < 1
		|| ROW_KEEP_W > 12 || TRP_CYC < 1 || TRP_CYC > 255 || TMRD_CYC < 1
		|| TMRD_CYC > 255) begin : g_bad
		$error("sdc_device: unsupported parameter value");
	end

	// burst length in beats; zero means full page
	function automatic logic [COL_W:0] burst_len(input logic [2:0] code);
		case (code)
			`SDC_BL_TWO:   burst_len = (COL_W+1)'(2);
			`SDC_BL_FOUR:  burst_len = (COL_W+1)'(4);
			`SDC_BL_EIGHT: burst_len = (COL_W+1)'(8);
			`SDC_BL_PAGE:  burst_len = '0;
			default:       burst_len = (COL_W+1)'(1);
		endcase
	endfunction

	// column of beat k, wrapping inside the burst block
	function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] start,
		input logic [COL_W-1:0] k, input logic [2:0] code, input logic inter);
		logic [COL_W-1:0] msk;
		logic [COL_W-1:0] low;
		msk = COL_W'(burst_len(code) - (COL_W+1)'(1));
		low = (inter && code != `SDC_BL_PAGE) ? (start ^ k) : (start + k);
		beat_col = (start & ~msk) | (low & msk);
	endfunction

	// state
	logic [11:0]           mode_reg;
	logic [3:0]            bank_open_reg;
	logic [ROW_KEEP_W-1:0] row_reg [0:3];
	logic [CW-1:0]         trp_cnt_reg [0:3];
	logic [CW-1:0]         mrd_cnt_reg;
	sdc_burst_e            state_reg;
	logic [1:0]            bank_b_reg;
	logic [COL_W-1:0]      start_reg;
	logic [COL_W-1:0]      beat_reg;
	logic                  ap_reg;
	logic [11:0]           refresh_cnt_reg;
	logic                  self_ref_reg;
	logic                  err_reg;
	logic                  ovf_reg;
	logic                  fifo_rdy_reg;
	logic                  p0_valid_reg;
	logic [DQ_W-1:0]       p0_data_reg;
	logic                  p1_valid_reg;
	logic [DQ_W-1:0]       p1_data_reg;
	logic [LANES-1:0]      dqm_d1_reg;
	logic [DQ_W-1:0]       dq_reg;
	logic [DQ_W-1:0]       dq_oe_reg;
	logic [DQ_W-1:0]       mem [0:(1<<IDX_W)-1];

	// command decode
	wire sdc_cmd_e cmd = cs_n_i ? SDC_CMD_INH : sdc_cmd_e'({1'b0, ras_n_i, cas_n_i, we_n_i});
	wire logic live      = ce_i & cke_i & ~self_ref_reg;
	wire logic is_lmr    = live & (cmd == SDC_CMD_LMR);
	wire logic is_ref    = live & (cmd == SDC_CMD_REF);
	wire logic is_pre    = live & (cmd == SDC_CMD_PRE);
	wire logic is_act    = live & (cmd == SDC_CMD_ACT);
	wire logic is_wr     = live & (cmd == SDC_CMD_WR);
	wire logic is_rd     = live & (cmd == SDC_CMD_RD);
	wire logic is_bst    = live & (cmd == SDC_CMD_BST);
	wire logic is_exec   = is_lmr | is_ref | is_pre | is_act | is_wr | is_rd | is_bst;
	wire logic enter_sr  = ce_i & ~cke_i & ~self_ref_reg & (cmd == SDC_CMD_REF);
	wire logic leave_sr  = ce_i & cke_i & self_ref_reg;
	wire logic ap_bit    = addr_i[`SDC_AP_BIT];

	// mode word fields
	wire logic [2:0] bl_code   = mode_reg[`SDC_MODE_BL_MSB:`SDC_MODE_BL_LSB];
	wire logic       inter     = mode_reg[`SDC_MODE_BT_BIT];
	wire logic [2:0] cl_code   = mode_reg[`SDC_MODE_CL_MSB:`SDC_MODE_CL_LSB];
	wire logic       wsingle   = mode_reg[`SDC_MODE_WS_BIT];
	wire logic       cl3       = (cl_code == `SDC_CL_THREE);
	wire logic [2:0] new_cl    = addr_i[`SDC_MODE_CL_MSB:`SDC_MODE_CL_LSB];
	wire logic [1:0] new_op    = addr_i[`SDC_MODE_OP_MSB:`SDC_MODE_OP_LSB];

	// current beat: a new read/write restarts the engine at beat zero
	wire logic             new_rw   = is_rd | is_wr;
	wire logic             running  = (state_reg != SDC_IDLE) & ce_i & ~is_bst;
	wire logic             cur_act  = new_rw | running;
	wire logic             cur_rd   = new_rw ? is_rd : (state_reg == SDC_RD);
	wire logic [1:0]       cur_bank = new_rw ? ba_i : bank_b_reg;
	wire logic [COL_W-1:0] cur_start = new_rw ? addr_i[COL_W-1:0] : start_reg;
	wire logic [COL_W-1:0] cur_k    = new_rw ? '0 : beat_reg;
	wire logic             cur_ap   = new_rw ? ap_bit : ap_reg;
	wire logic [2:0]       cur_bl   = (~cur_rd & wsingle) ? `SDC_BL_ONE : bl_code;
	wire logic [COL_W:0]   cur_len  = burst_len(cur_bl);
	wire logic             cur_last = (cur_len != '0)
		&& (cur_k == COL_W'(cur_len - (COL_W+1)'(1)));
	wire logic [COL_W-1:0] cur_col  = beat_col(cur_start, cur_k, cur_bl, inter);
	wire logic [IDX_W-1:0] cur_idx  = {cur_bank, row_reg[cur_bank], cur_col};
	wire logic             auto_pre = cur_act & cur_last & cur_ap & (cur_len != '0);

	// engine next values
	wire sdc_burst_e state_next = (cur_act & ~cur_last) ? (cur_rd ? SDC_RD : SDC_WR) : SDC_IDLE;

	// write beats with their masks go to the buffer; fully masked beats are dropped
	wire logic          rd_beat  = cur_act & cur_rd;
	wire logic          wr_push  = cur_act & ~cur_rd & ~(&dqm_i);
	wire logic          fifo_in_rdy;
	wire logic          fifo_out_vld;
	wire logic [FW-1:0] fifo_out;
	wire logic          drain    = ce_i & ~rd_beat;

	// error causes
	wire logic mrd_busy  = (mrd_cnt_reg != '0);
	wire logic [3:0] trp_busy;
	wire logic lmr_bad   = is_lmr & ((bank_open_reg != '0) | (trp_busy != '0) | (ba_i != 2'h0)
		| ((new_cl != `SDC_CL_TWO) & (new_cl != `SDC_CL_THREE))
		| (new_op != `SDC_OP_NORMAL));
	wire logic act_bad   = is_act & (bank_open_reg[ba_i] | trp_busy[ba_i]);
	wire logic rw_bad    = new_rw & ~bank_open_reg[ba_i];
	wire logic ref_bad   = (is_ref | enter_sr) & ((bank_open_reg != '0) | (trp_busy != '0));
	wire logic err_now   = lmr_bad | act_bad | rw_bad | ref_bad | (is_exec & mrd_busy);

	// read output select by latency and per-lane enables from the delayed mask
	wire logic            sel_valid = cl3 ? p1_valid_reg : p0_valid_reg;
	wire logic [DQ_W-1:0] sel_data  = cl3 ? p1_data_reg : p0_data_reg;
	logic [DQ_W-1:0]      oe_next;
	always_comb begin
		oe_next = '0;
		for (int l = 0; l < LANES; l++) begin
			oe_next[l*LW +: LW] = {LW{sel_valid & ~dqm_d1_reg[l]}};
		end
	end

	genvar b;
	for (b = 0; b < 4; b++) begin : g_bank
		assign trp_busy[b] = (trp_cnt_reg[b] != '0);
		wire logic hit_pre = is_pre & (ap_bit | (ba_i == 2'(b)));
		wire logic hit_ap  = auto_pre & (cur_bank == 2'(b));
		wire logic hit_act = is_act & (ba_i == 2'(b));

		// open flag, row and precharge wait per bank
		always_ff @(posedge clock_i or posedge reset_i) begin
			if (reset_i) begin
				bank_open_reg[b] <= 1'b0;
				row_reg[b]       <= '0;
				trp_cnt_reg[b]   <= '0;
			end else if (ce_i) begin
				if (hit_pre | hit_ap) begin
					bank_open_reg[b] <= 1'b0;
					trp_cnt_reg[b]   <= CW'(TRP_CYC);
				end else begin
					if (hit_act) begin
						bank_open_reg[b] <= 1'b1;
						row_reg[b]       <= addr_i[ROW_KEEP_W-1:0];
					end
					if (trp_busy[b]) begin
						trp_cnt_reg[b] <= trp_cnt_reg[b] - CW'(1);
					end
				end
			end
		end
	end

	// mode word load and its wait count
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			mode_reg    <= `SDC_MODE_RESET;
			mrd_cnt_reg <= '0;
		end else if (is_lmr) begin
			mode_reg    <= addr_i;
			mrd_cnt_reg <= CW'(TMRD_CYC);
		end else if (ce_i & mrd_busy) begin
			mrd_cnt_reg <= mrd_cnt_reg - CW'(1);
		end
	end

	// burst engine registers
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg  <= SDC_IDLE;
			bank_b_reg <= '0;
			start_reg  <= '0;
			beat_reg   <= '0;
			ap_reg     <= 1'b0;
		end else if (ce_i) begin
			state_reg  <= state_next;
			bank_b_reg <= cur_bank;
			start_reg  <= cur_start;
			beat_reg   <= cur_k + COL_W'(1);
			ap_reg     <= cur_ap;
		end
	end

	// refresh row counter and self refresh
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			refresh_cnt_reg <= '0;
			self_ref_reg    <= 1'b0;
		end else if (ce_i) begin
			if (is_ref | enter_sr) begin
				refresh_cnt_reg <= refresh_cnt_reg + 12'h001;
			end
			if (enter_sr) begin
				self_ref_reg <= 1'b1;
			end else if (leave_sr) begin
				self_ref_reg <= 1'b0;
			end
		end
	end

	// sticky error and overflow flags, buffer ready
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			err_reg      <= 1'b0;
			ovf_reg      <= 1'b0;
			fifo_rdy_reg <= 1'b1;
		end else if (ce_i) begin
			err_reg      <= err_reg | err_now;
			ovf_reg      <= ovf_reg | (wr_push & ~fifo_in_rdy);
			fifo_rdy_reg <= fifo_in_rdy;
		end
	end

	// array port: read beats first, buffered writes drain when free
	always_ff @(posedge clock_i) begin
		if (ce_i & rd_beat) begin
			p0_data_reg <= mem[cur_idx];
		end else if (drain & fifo_out_vld) begin
			for (int l = 0; l < LANES; l++) begin
				if (~fifo_out[DQ_W + l]) begin
					mem[fifo_out[FW-1 -: IDX_W]][l*LW +: LW] <= fifo_out[l*LW +: LW];
				end
			end
		end
	end

	// read pipeline and output stage
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			p0_valid_reg <= 1'b0;
			p1_valid_reg <= 1'b0;
			p1_data_reg  <= '0;
			dqm_d1_reg   <= '0;
			dq_reg       <= '0;
			dq_oe_reg    <= '0;
		end else if (ce_i) begin
			p0_valid_reg <= rd_beat;
			p1_valid_reg <= p0_valid_reg;
			p1_data_reg  <= p0_data_reg;
			dqm_d1_reg   <= dqm_i;
			dq_reg       <= sel_data;
			dq_oe_reg    <= oe_next;
		end
	end

	// write beat buffer
	sdc_fifo #(
		.W     (FW),
		.DEPTH (FIFO_DEPTH)
	) u_wbuf (
		.clock_i     (clock_i),
		.reset_i     (reset_i),
		.en_i        (ce_i),
		.in_valid_i  (wr_push),
		.in_ready_o  (fifo_in_rdy),
		.in_data_i   ({cur_idx, dqm_i, dq_i}),
		.out_valid_o (fifo_out_vld),
		.out_ready_i (drain),
		.out_data_o  (fifo_out)
	);

	// outputs straight from flops
	assign dq_o             = dq_reg;
	assign dq_oe_o          = dq_oe_reg;
	assign bank_open_o      = bank_open_reg;
	assign self_refresh_o   = self_ref_reg;
	assign refresh_row_o    = refresh_cnt_reg;
	assign protocol_error_o = err_reg;
	assign write_overflow_o = ovf_reg;
	assign wr_fifo_ready_o  = fifo_rdy_reg;

endmodule // sdc_device

`default_nettype wire

// *** testbench/sdc_device_assertions.sv ***
// checker for sdc_device: latency, masks, bank state, refresh and faults
`timescale 1ns/1ps
`default_nettype none

module sdc_chk #(
	parameter int DQ_W  = 16,
	parameter int LANES = 2
) (
	input wire logic             clock_i,
	input wire logic             reset_i,
	input wire logic             ce_i,
	input wire logic             cke_i,
	input wire logic             cs_n_i,
	input wire logic             ras_n_i,
	input wire logic             cas_n_i,
	input wire logic             we_n_i,
	input wire logic [1:0]       ba_i,
	input wire logic [11:0]      addr_i,
	input wire logic [LANES-1:0] dqm_i,
	input wire logic [DQ_W-1:0]  dq_oe_o,
	input wire logic [3:0]       bank_open_o,
	input wire logic             self_refresh_o,
	input wire logic [11:0]      refresh_row_o,
	input wire logic             protocol_error_o
);
	// command taken at this edge and its strobe code
	wire       taken = ce_i && cke_i && !self_refresh_o && !cs_n_i;
	wire [2:0] code  = {ras_n_i, cas_n_i, we_n_i};
	logic      cl3_reg;

	// latency three tracked from mode loads
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i)
			cl3_reg <= 1'b0;
		else if (taken && code == 3'h0)
			cl3_reg <= (addr_i[6:4] == 3'h3);
	end

	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);

	sequence rd_s;
		taken && code == 3'h5 && dqm_i == '0;
	endsequence
	sequence lmr_s;
		taken && code == 3'h0;
	endsequence

	rd_cl2_a: assert property (rd_s ##0 !cl3_reg |-> ##2 dq_oe_o == '1)
		else $error("latency two read not driven");
	rd_cl3_a: assert property (rd_s ##0 cl3_reg ##1 dqm_i == '0 |-> ##2 dq_oe_o == '1)
		else $error("latency three read not driven");
	rd_mask_a: assert property (ce_i && dqm_i[0] |-> ##2 dq_oe_o[DQ_W/LANES-1:0] == '0)
		else $error("masked read lane driven");
	act_open_a: assert property (taken && code == 3'h3 |=> bank_open_o[$past(ba_i)])
		else $error("row not opened");
	pre_one_a: assert property (taken && code == 3'h2 && !addr_i[10]
		|=> !bank_open_o[$past(ba_i)])
		else $error("bank not closed");
	pre_all_a: assert property (taken && code == 3'h2 && addr_i[10] |=> bank_open_o == 4'h0)
		else $error("banks not all closed");
	ref_row_a: assert property (taken && code == 3'h1
		|=> refresh_row_o == $past(refresh_row_o) + 12'h001)
		else $error("refresh row not advanced");
	idle_row_a: assert property (cs_n_i || (taken && code == 3'h7) |=> $stable(refresh_row_o))
		else $error("idle command changed state");
	sr_enter_a: assert property (ce_i && !cs_n_i && !cke_i && !self_refresh_o && code == 3'h1
		|=> self_refresh_o)
		else $error("self refresh not entered");
	sr_exit_a: assert property (ce_i && cke_i && self_refresh_o |=> !self_refresh_o)
		else $error("self refresh not left");
	lmr_bad_a: assert property (lmr_s ##0 (addr_i[6:5] != 2'h1 || addr_i[8:7] != 2'h0)
		|-> ##[1:2] protocol_error_o)
		else $error("bad mode word not flagged");
	mode_gap_a: assert property (lmr_s ##1 (taken && code != 3'h7)
		|-> ##[1:2] protocol_error_o)
		else $error("mode gap breach not flagged");
endmodule // sdc_chk

`default_nettype wire

// *** testbench/sdc_ctrl_model.sv ***
// controller-side model: turns a command code into select and strobe pins
`timescale 1ns/1ps
`default_nettype none

module sdc_ctrl_model
	import sdc_pkg::*;
(
	input  wire sdc_cmd_e   cmd_i,
	input  wire logic [1:0] ba_i,
	output logic            cs_n_o,
	output logic            ras_n_o,
	output logic            cas_n_o,
	output logic            we_n_o,
	output logic [1:0]      ba_o
);
	// code is {inhibit, ras, cas, we}
	assign {cs_n_o, ras_n_o, cas_n_o, we_n_o} = cmd_i;
	// mode loads go out with bank select zero
	assign ba_o = (cmd_i == SDC_CMD_LMR) ? 2'h0 : ba_i;
endmodule // sdc_ctrl_model

`default_nettype wire

// *** testbench/test_sdram_command_decode_and_mode.sv ***
// bench for sdc_device: command table, data paths, self refresh, faults
`timescale 1ns/1ps
`default_nettype none

module test_sdram_command_decode_and_mode import sdc_pkg::*;;
	typedef struct packed {
		sdc_cmd_e    c;
		logic [1:0]  b;
		logic [11:0] a;
		logic [3:0]  o;
	} sdc_row_s;
	logic        clock_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        cke_i = 1'b1;
	logic        ce = 1'b1;
	sdc_cmd_e    cmd = SDC_CMD_NOP;
	logic [1:0]  ba = 2'h0;
	logic [11:0] addr_i = 12'h000;
	logic [1:0]  dqm_i = 2'h0;
	logic [15:0] dq_i = 16'h0000;
	logic        cs_n, ras_n, cas_n, we_n;
	logic [1:0]  ba_w;
	logic [15:0] dq_o, dq_oe_o;
	logic [3:0]  bank_open_o;
	logic        self_refresh_o, protocol_error_o, write_overflow_o, wr_fifo_ready_o;
	logic [11:0] refresh_row_o;
	int          mismatches = 0;
	int          check_count = 0;
	logic [11:0] bad [4] = '{12'h010, 12'h040, 12'h0A0, 12'h120};
	// command, bank, address, banks open afterwards
	sdc_row_s    rows [12] = '{
		'{SDC_CMD_LMR, 2'h0, 12'h020, 4'h0}, '{SDC_CMD_ACT, 2'h0, 12'h000, 4'h1},
		'{SDC_CMD_ACT, 2'h1, 12'h123, 4'h3}, '{SDC_CMD_ACT, 2'h2, 12'hFFF, 4'h7},
		'{SDC_CMD_PRE, 2'h1, 12'h000, 4'h5}, '{SDC_CMD_PRE, 2'h3, 12'h400, 4'h0},
		'{SDC_CMD_REF, 2'h3, 12'hFFF, 4'h0}, '{SDC_CMD_ACT, 2'h3, 12'h001, 4'h8},
		'{SDC_CMD_BST, 2'h3, 12'h000, 4'h8}, '{SDC_CMD_NOP, 2'h0, 12'h000, 4'h8},
		'{SDC_CMD_INH, 2'h0, 12'h000, 4'h8}, '{SDC_CMD_PRE, 2'h0, 12'h400, 4'h0}};

	always #10 clock_i = ~clock_i;

	sdc_ctrl_model i_ctrl (.cmd_i(cmd), .ba_i(ba), .cs_n_o(cs_n), .ras_n_o(ras_n),
		.cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba_w));
	sdc_device #(.TRP_CYC(1), .TMRD_CYC(2)) i_dut (.clock_i(clock_i), .reset_i(reset_i),
		.ce_i(ce), .cke_i(cke_i), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n),
		.we_n_i(we_n), .ba_i(ba_w), .addr_i(addr_i), .dqm_i(dqm_i), .dq_i(dq_i),
		.dq_o(dq_o), .dq_oe_o(dq_oe_o), .bank_open_o(bank_open_o),
		.self_refresh_o(self_refresh_o), .refresh_row_o(refresh_row_o),
		.protocol_error_o(protocol_error_o), .write_overflow_o(write_overflow_o),
		.wr_fifo_ready_o(wr_fifo_ready_o));

	// compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one command at a falling edge, then gap idle cycles
	task automatic op(input sdc_cmd_e c, input logic [1:0] b, input logic [11:0] a,
		input logic [15:0] d, input logic [1:0] m, input int gap);
		@(negedge clock_i);
		cmd = c;
		ba = b;
		addr_i = a;
		dq_i = d;
		dqm_i = m;
		repeat (gap) begin
			@(negedge clock_i);
			cmd = SDC_CMD_NOP;
			dqm_i = 2'h0;
		end
	endtask

	task automatic do_reset;
		reset_i = 1'b1;
		repeat (5) @(negedge clock_i);
		reset_i = 1'b0;
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// watchdog against a hung run
	initial begin
		#50us;
		mismatches++;
		$display("watchdog expired");
		stop_test();
	end

	// main sequence
	initial begin
		do_reset();
		foreach (rows[i]) begin
			op(rows[i].c, rows[i].b, rows[i].a, 16'h0000, 2'h0, 3);
			check("bank_open", {12'h000, bank_open_o}, {12'h000, rows[i].o});
		end
		check("refresh_row", {4'h0, refresh_row_o}, 16'h0001);
		check("no fault", {15'h0, protocol_error_o}, 16'h0000);
		$display("test command table done");
		// writes with a masked lane, reads at latency two
		op(SDC_CMD_ACT, 2'h0, 12'h000, 16'h0000, 2'h0, 3);
		op(SDC_CMD_WR, 2'h0, 12'h004, 16'hA5C3, 2'h0, 1);
		op(SDC_CMD_WR, 2'h0, 12'h005, 16'h1234, 2'h0, 1);
		op(SDC_CMD_WR, 2'h0, 12'h007, 16'h0F0F, 2'h0, 1);
		op(SDC_CMD_WR, 2'h0, 12'h005, 16'hFFFF, 2'h1, 4);
		op(SDC_CMD_RD, 2'h0, 12'h005, 16'h0000, 2'h0, 2);
		check("cl2 data", dq_o, 16'hFF34);
		check("cl2 enable", dq_oe_o, 16'hFFFF);
		@(negedge clock_i);
		check("burst end", dq_oe_o, 16'h0000);
		op(SDC_CMD_RD, 2'h0, 12'h004, 16'h0000, 2'h2, 2);
		check("read mask", dq_oe_o, 16'h00FF);
		check("read low lane", {8'h00, dq_o[7:0]}, 16'h00C3);
		$display("test latency two done");
		// latency three, burst of two, single-location writes, auto precharge
		op(SDC_CMD_PRE, 2'h0, 12'h400, 16'h0000, 2'h0, 3);
		op(SDC_CMD_LMR, 2'h0, 12'h231, 16'h0000, 2'h0, 3);
		op(SDC_CMD_ACT, 2'h0, 12'h000, 16'h0000, 2'h0, 3);
		op(SDC_CMD_WR, 2'h0, 12'h006, 16'h7777, 2'h0, 0);
		op(SDC_CMD_NOP, 2'h0, 12'h000, 16'h8888, 2'h0, 4);
		op(SDC_CMD_RD, 2'h0, 12'h406, 16'h0000, 2'h0, 1);
		check("open in burst", {12'h000, bank_open_o}, 16'h0001);
		@(negedge clock_i);
		check("cl3 early", dq_oe_o, 16'h0000);
		@(negedge clock_i);
		check("cl3 beat0", dq_o, 16'h7777);
		@(negedge clock_i);
		check("cl3 beat1", dq_o, 16'h0F0F);
		repeat (3) @(negedge clock_i);
		check("auto precharge", {12'h000, bank_open_o}, 16'h0000);
		check("no fault", {15'h0, protocol_error_o}, 16'h0000);
		$display("test latency three done");
		// self refresh entry and exit
		cke_i = 1'b0;
		cmd = SDC_CMD_REF;
		@(negedge clock_i);
		cmd = SDC_CMD_NOP;
		check("self refresh", {3'h0, self_refresh_o, refresh_row_o}, 16'h1002);
		cke_i = 1'b1;
		@(negedge clock_i);
		check("refresh exit", {15'h0, self_refresh_o}, 16'h0000);
		$display("test self refresh done");
		// bad mode words and a short mode gap, each after a fresh reset
		foreach (bad[i]) begin
			do_reset();
			op(SDC_CMD_LMR, 2'h0, bad[i], 16'h0000, 2'h0, 3);
			check("bad mode", {15'h0, protocol_error_o}, 16'h0001);
		end
		do_reset();
		check("reset state", {12'h000, wr_fifo_ready_o, protocol_error_o, self_refresh_o,
			write_overflow_o}, 16'h0008);
		op(SDC_CMD_LMR, 2'h0, 12'h020, 16'h0000, 2'h0, 0);
		op(SDC_CMD_ACT, 2'h1, 12'h000, 16'h0000, 2'h0, 3);
		check("mode gap", {15'h0, protocol_error_o}, 16'h0001);
		// clock enable low: a precharge all is not taken
		ce = 1'b0;
		op(SDC_CMD_PRE, 2'h0, 12'h400, 16'h0000, 2'h0, 2);
		check("ce freeze", {12'h000, bank_open_o}, 16'h0002);
		ce = 1'b1;
		@(negedge clock_i);
		check("ce resume", {12'h000, bank_open_o}, 16'h0002);
		$display("test faults done");
		stop_test();
	end
endmodule // test_sdram_command_decode_and_mode

bind sdc_device sdc_chk #(.DQ_W(DQ_W), .LANES(LANES)) i_chk (.clock_i(clock_i),
	.reset_i(reset_i), .ce_i(ce_i), .cke_i(cke_i), .cs_n_i(cs_n_i), .ras_n_i(ras_n_i),
	.cas_n_i(cas_n_i), .we_n_i(we_n_i), .ba_i(ba_i), .addr_i(addr_i), .dqm_i(dqm_i),
	.dq_oe_o(dq_oe_o), .bank_open_o(bank_open_o), .self_refresh_o(self_refresh_o),
	.refresh_row_o(refresh_row_o), .protocol_error_o(protocol_error_o));

`default_nettype wire
